// >>> rtl/lcr_lid_recal_ctrl.sv
// Lid closure detection, threshold broadcast and recalibration timing control
`timescale 1ns/1ps
`include "lcr_cfg.svh"
// Contract
// (R1) Status sets after 1..7 consecutive samples above threshold
// (R2) Queue depth code zero means one sample
// (R3) Independent queue per sensor, sets and clears
// (R4) Patterns used only while lid detection enabled
// (R5) Config bit 1 picks specific or count
// (R6) Specific mode: all pattern bits present in status
// (R7) Count mode: sensors 1-7 count meets pattern
// (R8) Count mode: grouped sensors count meets pattern
// (R9) Count mode: total count meets total; any suffices
// (R10) Both patterns zero disables and clears event
// (R11) Event reported as group status lid bit
// (R12) Patterns one bit per sensor, reset 7Fh
// (R13) Button broadcast copies sensor one threshold 2-7
// (R14) Group broadcast copies sensor one threshold to group
// (R15) Negative delta run 8/16/32 or off triggers recal
// (R16) Recal samples 16/32/64 else 256
// (R17) Update interval table, default code 011
// (R18) Recal settings shared by every sensor channel
// (R19) Status only set when output exceeds lid threshold
// (R20) Lid enable bit 7 gates evaluation, resets off
// (R21) Alert on event only when alert enable set
module lcr_lid_recal_ctrl
  import lcr_pkg::*;
#(
  parameter int unsigned P_UPD_LONG = `LCR_UPD_7936
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_reg_wr,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  input  wire logic              i_poll,
  input  wire lcr_pkg::lcr_sens_t i_lid_above,
  input  wire lcr_pkg::lcr_sens_t i_neg_delta,
  output lcr_pkg::lcr_sens_t     o_lid_status,
  output logic                   o_lid_event,
  output logic                   o_lid_alert,
  output lcr_pkg::lcr_sens_t     o_recal_trig,
  output logic                   o_base_update,
  output logic [8:0]             o_recal_samples,
  output logic [7:0]             o_thr_wr,
  output logic [6:0]             o_thr_data
);
  import lcr_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Interval counter is 13 bits wide
  if (P_UPD_LONG < 1 || P_UPD_LONG > 8191) begin : g_bad_upd
    $error("P_UPD_LONG out of range");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] lid_cfg_ff, nxt_lid_cfg;
  logic [2:0] queue_ff, nxt_queue;
  logic [6:0] pat_lo_ff, nxt_pat_lo;
  logic [6:0] pat_gr_ff, nxt_pat_gr;
  logic [7:0] recal_ff, nxt_recal;
  logic [7:0] rdata_ff, nxt_rdata;

  // Writes at the fixed offsets; reserved bits are dropped
  always_comb begin
    nxt_lid_cfg = lid_cfg_ff;
    nxt_queue   = queue_ff;
    nxt_pat_lo  = pat_lo_ff;
    nxt_pat_gr  = pat_gr_ff;
    nxt_recal   = recal_ff;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `LCR_ADDR_LID_CFG: nxt_lid_cfg = i_reg_wdata & 8'h83;
        `LCR_ADDR_QUEUE:   nxt_queue   = i_reg_wdata[2:0];
        `LCR_ADDR_PAT_LO:  nxt_pat_lo  = i_reg_wdata[6:0]; // R12
        `LCR_ADDR_PAT_GR:  nxt_pat_gr  = i_reg_wdata[6:0]; // R12
        `LCR_ADDR_RECAL:   nxt_recal   = i_reg_wdata & 8'hdf;
        default:           nxt_recal   = recal_ff;
      endcase
    end
  end

  // Read data registered; unmapped offsets return zero
  always_comb begin
    case (i_reg_addr)
      `LCR_ADDR_LID_CFG: nxt_rdata = lid_cfg_ff;
      `LCR_ADDR_QUEUE:   nxt_rdata = {5'h00, queue_ff};
      `LCR_ADDR_PAT_LO:  nxt_rdata = {1'b0, pat_lo_ff};
      `LCR_ADDR_PAT_GR:  nxt_rdata = {1'b0, pat_gr_ff};
      `LCR_ADDR_RECAL:   nxt_rdata = recal_ff;
      default:           nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lid_cfg_ff <= `LCR_RST_LID_CFG; // R20
      queue_ff   <= `LCR_RST_QUEUE;
      pat_lo_ff  <= `LCR_RST_PAT; // R12
      pat_gr_ff  <= `LCR_RST_PAT; // R12
      recal_ff   <= `LCR_RST_RECAL;
      rdata_ff   <= 8'h00;
    end else begin
      lid_cfg_ff <= nxt_lid_cfg;
      queue_ff   <= nxt_queue;
      pat_lo_ff  <= nxt_pat_lo;
      pat_gr_ff  <= nxt_pat_gr;
      recal_ff   <= nxt_recal;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  logic     lid_en, alert_en, btn_bcast, grp_bcast;
  lcr_cmp_t cmp_sel;
  lcr_neg_t neg_limit;
  logic [2:0] cal_code;
  logic [3:0] depth_need;

  assign lid_en    = lid_cfg_ff[`LCR_LID_EN_BIT];
  assign alert_en  = lid_cfg_ff[`LCR_ALERT_EN_BIT];
  assign cmp_sel   = lcr_cmp_t'(lid_cfg_ff[`LCR_CMP_SEL_BIT]); // R5
  assign btn_bcast = recal_ff[`LCR_BTN_BCAST_BIT];
  assign grp_bcast = recal_ff[`LCR_GRP_BCAST_BIT];
  assign neg_limit = lcr_neg_t'(recal_ff[`LCR_NEG_MSB:`LCR_NEG_LSB]);
  assign cal_code  = recal_ff[`LCR_CAL_MSB:`LCR_CAL_LSB];
  // Code zero is taken as a depth of one, the same as code one
  assign depth_need = (queue_ff == 3'h0) ? 4'd1 : {1'b0, queue_ff}; // R2

  // ----------------------------------------
  // Per-sensor filters and recalibration triggers
  // ----------------------------------------
  // One filter and one run counter per sensor, all sharing the same settings
  for (genvar g = 0; g < LCR_NSENS; g++) begin : g_sens
    lcr_lid_queue u_queue ( // R3
      .i_clk    (i_clk),
      .i_srst   (i_srst),
      .i_sample (i_poll),
      .i_above  (i_lid_above[g]), // R19
      .i_need   (depth_need),
      .o_status (o_lid_status[g])
    );
    lcr_neg_run u_neg ( // R18
      .i_clk    (i_clk),
      .i_srst   (i_srst),
      .i_sample (i_poll),
      .i_neg    (i_neg_delta[g]),
      .i_limit  (neg_limit),
      .o_trig   (o_recal_trig[g])
    );
  end

  // ----------------------------------------
  // Lid closure event
  // ----------------------------------------
  function automatic logic [2:0] pop7(input logic [6:0] v);
    logic [2:0] s;
    s = 3'd0;
    for (int i = 0; i < 7; i++) begin
      s = 3'(s + {2'b00, v[i]});
    end
    return s;
  endfunction

  logic [6:0] st_lo, st_gr;
  logic [2:0] pc_st_lo, pc_st_gr, pc_pat_lo, pc_pat_gr;
  logic [3:0] pc_st_tot, pc_pat_tot;
  logic       spec_hit, cnt_hit, both_zero;
  logic       event_ff, nxt_event, alert_ff, nxt_alert;

  assign st_lo      = o_lid_status[6:0];
  assign st_gr      = o_lid_status[13:7];
  assign pc_st_lo   = pop7(st_lo);
  assign pc_st_gr   = pop7(st_gr);
  assign pc_pat_lo  = pop7(pat_lo_ff);
  assign pc_pat_gr  = pop7(pat_gr_ff);
  assign pc_st_tot  = {1'b0, pc_st_lo} + {1'b0, pc_st_gr};
  assign pc_pat_tot = {1'b0, pc_pat_lo} + {1'b0, pc_pat_gr};
  assign both_zero  = (pat_lo_ff == 7'h00) && (pat_gr_ff == 7'h00);

  // Specific match: every masked sensor must be flagged
  assign spec_hit = ((st_lo & pat_lo_ff) == pat_lo_ff) && ((st_gr & pat_gr_ff) == pat_gr_ff); // R6

  // Count match: any of the three comparisons is enough
  assign cnt_hit = (pc_st_lo >= pc_pat_lo)     // R7
                || (pc_st_gr >= pc_pat_gr)     // R8
                || (pc_st_tot >= pc_pat_tot);  // R9

  // Evaluation gated by enable; empty patterns act as disabled
  always_comb begin
    nxt_event = 1'b0;
    if (lid_en && !both_zero) begin // R4 R20 R10
      nxt_event = (cmp_sel == LCR_CMP_SPECIFIC) ? spec_hit : cnt_hit; // R5
    end
    nxt_alert = nxt_event && alert_en; // R21
  end

  // Event is a level that follows the status one cycle later; nothing latches it for the host
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      event_ff <= 1'b0;
      alert_ff <= 1'b0;
    end else begin
      event_ff <= nxt_event; // R11
      alert_ff <= nxt_alert;
    end
  end

  assign o_lid_event = event_ff;
  assign o_lid_alert = alert_ff;

  // ----------------------------------------
  // Threshold write strobes and broadcast
  // ----------------------------------------
  logic [7:0] thr_wr_ff, nxt_thr_wr;
  logic [6:0] thr_data_ff, nxt_thr_data;

  // Index 0..6 are sensors 1..7, index 7 is the group threshold
  always_comb begin
    nxt_thr_wr   = 8'h00;
    nxt_thr_data = thr_data_ff;
    if (i_reg_wr && i_reg_addr >= `LCR_ADDR_THR_FIRST && i_reg_addr <= `LCR_ADDR_THR_GROUP) begin
      nxt_thr_data = i_reg_wdata[6:0];
      nxt_thr_wr[3'(i_reg_addr - `LCR_ADDR_THR_FIRST)] = 1'b1; // R13
      if (i_reg_addr == `LCR_ADDR_THR_FIRST) begin
        if (btn_bcast) begin
          nxt_thr_wr[6:1] = 6'h3f; // R13
        end
        if (grp_bcast) begin
          nxt_thr_wr[7] = 1'b1; // R14
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      thr_wr_ff   <= 8'h00;
      thr_data_ff <= 7'h00;
    end else begin
      thr_wr_ff   <= nxt_thr_wr;
      thr_data_ff <= nxt_thr_data;
    end
  end

  assign o_thr_wr   = thr_wr_ff;
  assign o_thr_data = thr_data_ff;

  // ----------------------------------------
  // Base count update interval and sample count
  // ----------------------------------------
  logic [12:0] upd_cnt_ff, nxt_upd_cnt, upd_len;
  logic        upd_ff, nxt_upd;
  logic [8:0]  smp_ff, nxt_smp;

  // Interval in polling cycles, one table for all sensors
  always_comb begin
    case (cal_code)
      3'h0:    upd_len = `LCR_UPD_16; // R17
      3'h1:    upd_len = `LCR_UPD_32;
      3'h2:    upd_len = `LCR_UPD_64;
      3'h3:    upd_len = `LCR_UPD_256;
      3'h4:    upd_len = `LCR_UPD_1024;
      3'h5:    upd_len = `LCR_UPD_2048;
      3'h6:    upd_len = `LCR_UPD_4096;
      default: upd_len = 13'(P_UPD_LONG);
    endcase
    case (cal_code)
      3'h0:    nxt_smp = `LCR_SMP_16; // R16
      3'h1:    nxt_smp = `LCR_SMP_32;
      3'h2:    nxt_smp = `LCR_SMP_64;
      default: nxt_smp = `LCR_SMP_256;
    endcase
  end

  // Compare with >= so a shorter interval written mid-count ends at once
  always_comb begin
    nxt_upd_cnt = upd_cnt_ff;
    nxt_upd     = 1'b0;
    if (i_poll) begin
      if (13'(upd_cnt_ff + 13'd1) >= upd_len) begin // R17 R18
        nxt_upd_cnt = 13'd0;
        nxt_upd     = 1'b1;
      end else begin
        nxt_upd_cnt = 13'(upd_cnt_ff + 13'd1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      upd_cnt_ff <= 13'd0;
      upd_ff     <= 1'b0;
      smp_ff     <= `LCR_SMP_256;
    end else begin
      upd_cnt_ff <= nxt_upd_cnt;
      upd_ff     <= nxt_upd;
      smp_ff     <= nxt_smp;
    end
  end

  assign o_base_update   = upd_ff;
  assign o_recal_samples = smp_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  depth_zero_a: assert property (queue_ff == 3'h0 |-> depth_need == 4'd1) // R2
    else $error("queue depth zero not taken as one");
  pat_reset_a: assert property ($past(i_srst) |-> pat_lo_ff == 7'h7f && pat_gr_ff == 7'h7f) // R12
    else $error("pattern reset value wrong");
  evt_disabled_a: assert property (!lid_en |=> !o_lid_event) // R20
    else $error("event raised while lid detection disabled");
  evt_zero_pat_a: assert property (both_zero |=> !o_lid_event ##0 !o_lid_alert) // R10
    else $error("event raised with empty patterns");
  evt_specific_a: assert property (lid_en && cmp_sel == LCR_CMP_SPECIFIC && !both_zero // R6
    |=> o_lid_event == $past(spec_hit))
    else $error("specific match result wrong");
  evt_count_a: assert property (lid_en && cmp_sel == LCR_CMP_COUNT && !both_zero // R9
    && (pc_st_lo >= pc_pat_lo || pc_st_gr >= pc_pat_gr || pc_st_tot >= pc_pat_tot) |=> o_lid_event)
    else $error("count match missed");
  alert_gate_a: assert property (o_lid_alert |-> o_lid_event && $past(alert_en)) // R21
    else $error("alert without event or enable");
  btn_bcast_a: assert property (i_reg_wr && i_reg_addr == `LCR_ADDR_THR_FIRST && btn_bcast // R13
    |=> o_thr_wr[6:0] == 7'h7f && o_thr_data == $past(i_reg_wdata[6:0]))
    else $error("button broadcast incomplete");
  grp_bcast_a: assert property (i_reg_wr && i_reg_addr == `LCR_ADDR_THR_FIRST // R14
    |=> o_thr_wr[7] == $past(grp_bcast))
    else $error("group broadcast wrong");
  upd_period_a: assert property (o_base_update |-> 13'($past(upd_cnt_ff) + 13'd1) >= $past(upd_len)) // R17
    else $error("base update before interval");

  spec_evt_c: cover property (cmp_sel == LCR_CMP_SPECIFIC && o_lid_event);
  cnt_evt_c: cover property (cmp_sel == LCR_CMP_COUNT && o_lid_event && o_lid_alert);
  long_upd_c: cover property (cal_code == 3'h7 && o_base_update);
endmodule

// >>> rtl/lcr_cfg.svh
// Register offsets, field positions, reset values and counts of the lid and recalibration control
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCR_ADDR_LID_CFG   8'h2b
`define LCR_ADDR_QUEUE     8'h2c
`define LCR_ADDR_PAT_LO    8'h2d
`define LCR_ADDR_PAT_GR    8'h2e
`define LCR_ADDR_RECAL     8'h2f
`define LCR_ADDR_THR_FIRST 8'h30
`define LCR_ADDR_THR_GROUP 8'h37
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCR_RST_LID_CFG    8'h00
`define LCR_RST_QUEUE      3'h2
`define LCR_RST_PAT        7'h7f
`define LCR_RST_RECAL      8'h93
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCR_LID_EN_BIT     7
`define LCR_CMP_SEL_BIT    1
`define LCR_ALERT_EN_BIT   0
`define LCR_BTN_BCAST_BIT  7
`define LCR_GRP_BCAST_BIT  6
`define LCR_NEG_MSB        4
`define LCR_NEG_LSB        3
`define LCR_CAL_MSB        2
`define LCR_CAL_LSB        0
// ----------------------------------------
// Counts, in samples or polling cycles
// ----------------------------------------
`define LCR_NEG_RUN_8      6'h08
`define LCR_NEG_RUN_16     6'h10
`define LCR_NEG_RUN_32     6'h20
`define LCR_SMP_16         9'h010
`define LCR_SMP_32         9'h020
`define LCR_SMP_64         9'h040
`define LCR_SMP_256        9'h100
`define LCR_UPD_16         13'h0010
`define LCR_UPD_32         13'h0020
`define LCR_UPD_64         13'h0040
`define LCR_UPD_256        13'h0100
`define LCR_UPD_1024       13'h0400
`define LCR_UPD_2048       13'h0800
`define LCR_UPD_4096       13'h1000
`define LCR_UPD_7936       7936
`endif

// >>> rtl/lcr_pkg.sv
// Types shared by the lid closure and recalibration control
package lcr_pkg;
  localparam int LCR_NSENS = 14;
  typedef logic [LCR_NSENS-1:0] lcr_sens_t;
  typedef enum logic [1:0] {
    LCR_NEG_8   = 2'b00,
    LCR_NEG_16  = 2'b01,
    LCR_NEG_32  = 2'b10,
    LCR_NEG_OFF = 2'b11
  } lcr_neg_t;
  typedef enum logic {
    LCR_CMP_COUNT    = 1'b0,
    LCR_CMP_SPECIFIC = 1'b1
  } lcr_cmp_t;
endpackage

// >>> rtl/lcr_lid_queue.sv
// Per-sensor consecutive-sample filter for one lid status bit
`timescale 1ns/1ps
module lcr_lid_queue (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_sample,
  input  wire logic       i_above,
  input  wire logic [3:0] i_need,
  output logic            o_status
);
  logic       status_ff, nxt_status;
  logic [3:0] run_ff, nxt_run;

  // Count samples that disagree with the bit; flip once the run reaches the depth
  always_comb begin
    nxt_status = status_ff;
    nxt_run    = run_ff;
    if (i_sample) begin
      if (i_above != status_ff) begin // R3
        if (4'(run_ff + 4'd1) >= i_need) begin // R1
          nxt_status = i_above; // R19
          nxt_run    = 4'd0;
        end else begin
          nxt_run = 4'(run_ff + 4'd1);
        end
      end else begin
        nxt_run = 4'd0; // Broken run starts over
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status_ff <= 1'b0;
      run_ff    <= 4'd0;
    end else begin
      status_ff <= nxt_status;
      run_ff    <= nxt_run;
    end
  end

  assign o_status = status_ff;

  queue_flip_a: assert property (@(posedge i_clk) disable iff (i_srst) // R1
    (status_ff != $past(status_ff)) |-> $past(i_sample) && $past(i_above) == status_ff)
    else $error("lid status changed without a qualifying sample");
endmodule

// >>> rtl/lcr_neg_run.sv
// Per-sensor run counter of consecutive negative deltas that triggers recalibration
`timescale 1ns/1ps
module lcr_neg_run
  import lcr_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_sample,
  input  wire logic             i_neg,
  input  wire lcr_pkg::lcr_neg_t i_limit,
  output logic                  o_trig
);
`include "lcr_cfg.svh"
  logic [5:0] cnt_ff, nxt_cnt, limit;
  logic       trig_ff, nxt_trig;

  // Run length decode; the disabled code decodes to zero and its run is held cleared
  always_comb begin
    case (i_limit)
      LCR_NEG_8:  limit = `LCR_NEG_RUN_8;
      LCR_NEG_16: limit = `LCR_NEG_RUN_16;
      LCR_NEG_32: limit = `LCR_NEG_RUN_32;
      default:    limit = 6'h00;
    endcase
  end

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_trig = 1'b0;
    if (i_limit == LCR_NEG_OFF || (i_sample && !i_neg)) begin
      nxt_cnt = 6'h00;
    end else if (i_sample) begin
      if (6'(cnt_ff + 6'h01) >= limit) begin // R15
        nxt_trig = 1'b1;
        nxt_cnt  = 6'h00;
      end else begin
        nxt_cnt = 6'(cnt_ff + 6'h01);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff  <= 6'h00;
      trig_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      trig_ff <= nxt_trig;
    end
  end

  assign o_trig = trig_ff;

  neg_trig_a: assert property (@(posedge i_clk) disable iff (i_srst) // R15
    o_trig |-> $past(i_limit) != LCR_NEG_OFF && $past(i_neg) && $past(i_sample))
    else $error("recalibration trigger without a negative run");
endmodule

// >>> sim/lcr_sens_model.sv
// Sensor front-end model that reports per-sensor samples on each polling pulse
`timescale 1ns/1ps
module lcr_sens_model
  import lcr_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_req,
  input  wire lcr_pkg::lcr_sens_t i_above,
  input  wire lcr_pkg::lcr_sens_t i_neg,
  output logic                    o_poll,
  output lcr_pkg::lcr_sens_t      o_above,
  output lcr_pkg::lcr_sens_t      o_neg
);
  // ----------------------------------------
  // Off-sample filler
  // ----------------------------------------
  // Lines carry junk between polls so stale values are never mistaken for samples
  lcr_sens_t junk_ff = '0;
  always @(posedge i_clk) begin
    junk_ff <= i_req ? ~i_above : ~junk_ff;
  end
  // Sample presented only for the poll cycle
  assign o_poll  = i_req;
  assign o_above = i_req ? i_above : junk_ff;
  assign o_neg   = i_req ? i_neg : ~junk_ff;
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the lid closure and recalibration control
`timescale 1ns/1ps
module tb_top;
  import lcr_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  localparam int P_LONG = 20;  // Shrunk longest update interval
  localparam int LIM    = 90000;
  localparam logic [7:0] RA [5] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h02, 8'h7f, 8'h7f, 8'h93};
  localparam logic [7:0] RM [5] = '{8'h83, 8'h07, 8'h7f, 8'h7f, 8'hdf};
  localparam logic [7:0] BC [4] = '{8'h13, 8'h53, 8'h93, 8'hd3};
  localparam int DQ [4] = '{0, 1, 3, 7};
  localparam int UPD [8] = '{16, 32, 64, 256, 1024, 2048, 4096, P_LONG};
  logic       clk   = 1'b0;
  logic       srst  = 1'b1;
  logic       wr    = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       req   = 1'b0;
  lcr_sens_t  abv   = '0;
  lcr_sens_t  neg   = '0;
  lcr_sens_t  trig_seen = '0;
  logic [7:0] rdata;
  logic       poll;
  lcr_sens_t  p_abv;
  lcr_sens_t  p_neg;
  lcr_sens_t  status;
  lcr_sens_t  trig;
  logic       ev_o;
  logic       alert;
  logic       bupd;
  logic [8:0] smp;
  logic [7:0] thr_wr;
  logic [6:0] thr_data;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         bu_cnt = 0;
  lcr_lid_recal_ctrl #(.P_UPD_LONG(P_LONG)) u_dut (
    .i_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_poll(poll),
    .i_lid_above(p_abv), .i_neg_delta(p_neg), .o_lid_status(status),
    .o_lid_event(ev_o), .o_lid_alert(alert), .o_recal_trig(trig),
    .o_base_update(bupd), .o_recal_samples(smp), .o_thr_wr(thr_wr),
    .o_thr_data(thr_data)
  );
  lcr_sens_model u_sens (
    .i_clk(clk), .i_req(req), .i_above(abv), .i_neg(neg),
    .o_poll(poll), .o_above(p_abv), .o_neg(p_neg)
  );
  // ----------------------------------------
  // Clock, hang guard, pulse capture
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIM) begin
      miscompares++;
      give_verdict();
    end
  end
  // Pulses are gathered at the falling edge so their exact cycle does not matter
  always @(negedge clk) begin
    trig_seen |= trig;
    if (bupd === 1'b1) bu_cnt++;
  end
  // ----------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk(16'(rdata), 16'(e));
  endtask
  // One poll takes two cycles and ends just after a rising edge
  task automatic pol(input lcr_sens_t a, input lcr_sens_t n);
    @(negedge clk);
    req = 1'b1;
    abv = a;
    neg = n;
    @(negedge clk);
    req = 1'b0;
    @(posedge clk);
    #1;
  endtask
  function automatic logic exp_ev(logic [7:0] c, logic [6:0] p1, logic [6:0] p2, lcr_sens_t s);
    int a1 = $countones(s[6:0]);
    int a2 = $countones(s[13:7]);
    if (!c[7] || (p1 == 7'h00 && p2 == 7'h00)) return 1'b0;
    if (c[1]) return ((s[6:0] & p1) == p1) && ((s[13:7] & p2) == p2);
    return a1 >= $countones(p1) || a2 >= $countones(p2) || a1 + a2 >= $countones({p1, p2});
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    lcr_sens_t  s;
    logic [7:0] c;
    logic [7:0] d;
    logic [6:0] p1;
    logic [6:0] p2;
    logic       e;
    int         n;
    int         b;
    void'($urandom(32'hfcc933fa));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    chk(16'(smp), 16'h0100);
    // Reset values, reserved bits, unmapped offset
    for (int k = 0; k < 5; k++) begin
      rreg(RA[k], RV[k]);
      wreg(RA[k], 8'hff);
      rreg(RA[k], RM[k]);
      wreg(RA[k], RV[k]);
    end
    wreg(8'h50, 8'hff);
    rreg(8'h50, 8'h00);
    repeat (4) begin
      d = 8'($urandom);
      wreg(8'h2e, d);
      rreg(8'h2e, d & 8'h7f);
    end
    $display("test registers done");
    // Threshold broadcast under every pair of enables
    for (int k = 0; k < 4; k++) begin
      wreg(8'h2f, BC[k]);
      d = 8'($urandom);
      wreg(8'h30, d);
      chk(16'(thr_wr), 16'({BC[k][6], {6{BC[k][7]}}, 1'b1}));
      chk(16'(thr_data), 16'(d[6:0]));
      @(negedge clk);
      chk(16'(thr_wr), 16'h0000);
    end
    for (int k = 1; k < 8; k++) begin
      d = 8'($urandom);
      wreg(8'(8'h30 + k), d);
      chk(16'(thr_wr), 16'(1 << k));
      chk(16'(thr_data), 16'(d[6:0]));
    end
    $display("test thresholds done");
    // Queue depth: set and clear, broken runs on sensor 14
    wreg(8'h2b, 8'h80);
    for (int k = 0; k < 4; k++) begin
      n = (DQ[k] == 0) ? 1 : DQ[k];
      wreg(8'h2c, 8'(DQ[k]));
      repeat (n) pol('0, '0);
      chk(16'(status), 16'h0000);
      repeat (n - 1) pol(14'h2001, '0);
      chk(16'(status), 16'h0000);
      pol(14'h0001, '0);
      chk(16'(status), 16'h0001);
      repeat (n - 1) pol('0, '0);
      chk(16'(status), 16'h0001);
      pol('0, '0);
      chk(16'(status), 16'h0000);
    end
    $display("test queue done");
    // Event decisions with random configs, patterns and sensor states
    wreg(8'h2c, 8'h00);
    for (int k = 0; k < 60; k++) begin
      c = 8'($urandom) & 8'h03;
      c[7] = (k % 4 != 3);
      p1 = 7'($urandom);
      p2 = 7'($urandom);
      s = 14'($urandom);
      if (k < 2) begin
        p1 = 7'h00;
        p2 = 7'h00;
      end
      if (c[1] && k % 2 == 1) s |= {p2, p1};
      wreg(8'h2b, c);
      wreg(8'h2d, 8'(p1));
      wreg(8'h2e, 8'(p2));
      pol(s, '0);
      if (c[7]) chk(16'(status), 16'(s));
      repeat (2) @(negedge clk);
      e = exp_ev(c, p1, p2, s);
      chk(16'(ev_o), 16'(e));
      chk(16'(alert), 16'(e & c[0]));
    end
    $display("test events done");
    // Negative delta runs; sensor 1 breaks its run once
    for (int k = 0; k < 4; k++) begin
      wreg(8'h2f, 8'(8'h80 | (k << 3)));
      n = (k == 3) ? 40 : (8 << k);
      pol('0, '0);
      repeat (2) @(posedge clk);
      #1;
      trig_seen = '0;
      for (int i = 0; i < n - 1; i++) pol('0, (i == 1) ? 14'h3ffe : 14'h3fff);
      repeat (2) @(posedge clk);
      #1;
      chk(16'(trig_seen), 16'h0000);
      trig_seen = '0;
      pol('0, 14'h3fff);
      repeat (2) @(posedge clk);
      #1;
      chk(16'(trig_seen), (k == 3) ? 16'h0000 : 16'h3ffe);
    end
    $display("test negative runs done");
    // Averaging size and base update interval for every code
    for (int k = 0; k < 8; k++) begin
      wreg(8'h2f, 8'(8'h98 | k));
      repeat (2) @(negedge clk);
      chk(16'(smp), (k < 3) ? 16'(16 << k) : 16'h0100);
      for (int j = 0; j < 2; j++) begin
        b = bu_cnt;
        n = 0;
        while (bu_cnt == b && n < 5000) begin
          pol('0, '0);
          n++;
        end
      end
      chk(16'(n), 16'(UPD[k]));
    end
    $display("test base updates done");
    give_verdict();
  end
endmodule
